//--- design/flash_ctl_pkg.sv
// Package for the parallel flash erase controller: commands, register map, timing
// Functional notes
// RULE1: A successful block erase leaves every bit of the block at one.
// RULE2: Erase starts with 20h at any address, then D0h inside the block.
// RULE3: Confirm starts erasing the block that holds the confirm address.
// RULE4: A wrong code after setup sets write and erase error bits.
// RULE5: During erase every read returns status on the low data lines.
// RULE6: Erase done sets ready; status read mode holds until next command.
// RULE7: Boot block erase needs unlock voltage or write-protect high with supply.
// RULE8: During erase only suspend may be issued.
// RULE9: Suspended state sets suspend bit and ready bit.
// RULE10: While suspended only read array, resume, read status are issued.
// RULE11: Read array in suspend returns data outside the suspended block.
// RULE12: Resume before the suspend bit sets continues erase at once.
// RULE13: After ready, supply, write or erase error bits mean an error.
// RULE14: Error bits clear only by clear status command 50h.
// RULE15: Supply error bit set blocks further write or erase.
// RULE16: Bits 5 and 4 together mean sequencing error; bit 3 bad supply.
// RULE17: Reset/power-down pin low puts the device in deep power-down.
// RULE18: Chip select high means standby; a running erase continues.
// RULE19: After power-up or reset the status clears and array read starts.
// RULE20: During ramp hold reset low, or hold select high while pulsing reset.
// RULE21: After erase, FFh must be written before array reads.
// RULE22: Suspend bit stays one until erase resume.
// RULE23: Erase error bit sets when erase retries are exhausted.
// RULE24: Erase block is decoded from address bits 12 through 19.
// RULE25: Suspend is B0h, resume is D0h, both at any address.
package flash_ctl_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam int SR_SUPPLY = 3;
  localparam int SR_WRITE_ERR = 4;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_SUSPENDED = 6;
  localparam int SR_READY = 7;
  localparam int BLK_LO = 12;
  localparam int BLK_HI = 19;
  // Software register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_DATA = 4'h3;
  localparam logic [3:0] REG_ERR = 4'h4;
  localparam logic [3:0] REG_PIN = 4'h5;
  // Control opcodes written to REG_CTRL[2:0]
  localparam logic [2:0] OP_ERASE = 3'h1;
  localparam logic [2:0] OP_SUSPEND = 3'h2;
  localparam logic [2:0] OP_RESUME = 3'h3;
  localparam logic [2:0] OP_CLEAR = 3'h4;
  localparam logic [2:0] OP_READ_ARRAY = 3'h5;
  localparam logic [2:0] OP_READ_STATUS = 3'h6;
  localparam logic [2:0] OP_READ = 3'h7;
  // Bus timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_STROBE_NS = 100;
  localparam int T_RESET_LOW_NS = 60;
  localparam int T_RESET_REC_NS = 1000;
  localparam int STROBE_CYC = (T_STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_LOW_CYC = (T_RESET_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_REC_CYC = (T_RESET_REC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 8;

  typedef struct packed {
    logic chip_sel_n;
    logic wr_n;
    logic rd_n;
    logic [ADDR_W-1:0] addr;
  } flash_ctl_s;

  typedef struct packed {
    logic [DATA_W-1:0] wdata;
    logic wdata_oe;
  } flash_dout_s;

  typedef struct packed {
    logic [2:0] op;
    logic start;
  } order_s;
endpackage

//--- design/flash_bus_cycle.sv
// Single flash bus cycle engine: one write or one read, timed in clock cycles
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle #(
  parameter int STROBE_CYC = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic is_read,
  input wire logic [flash_ctl_pkg::ADDR_W-1:0] addr,
  input wire logic [flash_ctl_pkg::DATA_W-1:0] wdata,
  input wire logic [flash_ctl_pkg::DATA_W-1:0] data_in,
  output flash_ctl_pkg::flash_ctl_s ctl,
  output flash_ctl_pkg::flash_dout_s dout,
  output logic [flash_ctl_pkg::DATA_W-1:0] rdata,
  output logic done
);
  import flash_ctl_pkg::*;

  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} cyc_e;
  cyc_e st_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic rd_ff;
  wire cnt_zero = (cnt_ff == '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= CY_IDLE;
      cnt_ff <= '0;
      rd_ff <= 1'b0;
      ctl <= '{chip_sel_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, addr: '0};
      dout <= '0;
      rdata <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (st_ff)
        CY_IDLE: begin
          if (go) begin
            st_ff <= CY_SETUP;
            rd_ff <= is_read;
            ctl.addr <= addr;
            ctl.chip_sel_n <= 1'b0;
            dout.wdata <= wdata;
            dout.wdata_oe <= !is_read;
          end
        end
        CY_SETUP: begin
          st_ff <= CY_STROBE;
          cnt_ff <= CNT_W'(STROBE_CYC - 1);
          if (rd_ff) begin
            ctl.rd_n <= 1'b0;
          end else begin
            ctl.wr_n <= 1'b0;
          end
        end
        CY_STROBE: begin
          if (cnt_zero) begin
            st_ff <= CY_HOLD;
            ctl.wr_n <= 1'b1;
            ctl.rd_n <= 1'b1;
            if (rd_ff) begin
              rdata <= data_in;
            end
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        CY_HOLD: begin
          // Chip select released between cycles gives the device standby [RULE18]
          st_ff <= CY_IDLE;
          ctl.chip_sel_n <= 1'b1;
          dout.wdata_oe <= 1'b0;
          done <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- design/flash_erase_host.sv
// Host controller that sequences block erase, suspend, resume and status on a flash
`timescale 1ns/1ps
`default_nettype none
module flash_erase_host #(
  parameter int STROBE_CYC = flash_ctl_pkg::STROBE_CYC,
  parameter int RESET_LOW_CYC = flash_ctl_pkg::RESET_LOW_CYC,
  parameter int RESET_REC_CYC = flash_ctl_pkg::RESET_REC_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output flash_ctl_pkg::flash_ctl_s flash_ctl,
  output flash_ctl_pkg::flash_dout_s flash_dout,
  input wire logic [flash_ctl_pkg::DATA_W-1:0] flash_din,
  output logic reset_powerdown_n,
  output logic boot_unlock_voltage,
  output logic write_protect_n,
  output logic program_supply_high
);
  import flash_ctl_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  wire rst_n = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_PWRUP, S_RECOVER, S_IDLE, S_SETUP_WR, S_CONFIRM_WR, S_POLL,
    S_SUSP_WR, S_RESUME_WR, S_CMD_WR, S_READ
  } seq_e;
  seq_e st_ff, nxt_st;

  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] status_ff, data_ff;
  logic [2:0] pend_ff;
  logic busy_ff, erasing_ff, suspended_ff, boot_ff, pwrdn_ff, susp_req_ff;
  logic [BLK_HI-BLK_LO:0] blk_ff;
  logic [CNT_W+2:0] tmr_ff;

  wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
  wire [2:0] op = reg_wdata[2:0];
  wire cyc_done;
  wire [DATA_W-1:0] cyc_rdata;
  logic cyc_go, cyc_read;
  logic [DATA_W-1:0] cyc_wdata;
  logic [ADDR_W-1:0] cyc_addr;

  // Error decode of a status byte [RULE13] [RULE16]
  function automatic logic [2:0] err_decode(input logic [DATA_W-1:0] sr);
    err_decode[0] = sr[SR_READY] && sr[SR_ERASE_ERR] && sr[SR_WRITE_ERR];
    err_decode[1] = sr[SR_READY] && sr[SR_SUPPLY];
    err_decode[2] = sr[SR_READY] && (sr[SR_ERASE_ERR] || sr[SR_WRITE_ERR] || sr[SR_SUPPLY]);
  endfunction

  wire [2:0] err_now = err_decode(status_ff);
  // Supply error inhibits new erase until cleared [RULE15]
  wire erase_ok = !status_ff[SR_SUPPLY];
  // Legal orders: only suspend while erasing [RULE8], three commands plus read while suspended [RULE10]
  wire op_legal = !busy_ff && !pwrdn_ff && (
    erasing_ff ? (suspended_ff ? (op == OP_RESUME || op == OP_READ_ARRAY ||
                                  op == OP_READ_STATUS || op == OP_READ)
                               : (op == OP_SUSPEND))
               : (op != OP_SUSPEND && op != OP_RESUME &&
                  (op != OP_ERASE || erase_ok)));
  // Reads inside the suspended block are not served by the device [RULE11]
  wire same_blk = (reg_wdata[BLK_HI+8:BLK_LO+8] == blk_ff);
  // Suspend is taken while a running erase is being polled [RULE8]
  wire susp_take = (st_ff == S_POLL) && wr_ctrl && (op == OP_SUSPEND) &&
                   erasing_ff && !suspended_ff;

  always_comb begin
    nxt_st = st_ff;
    cyc_go = 1'b0;
    cyc_read = 1'b0;
    cyc_wdata = CMD_READ_ARRAY;
    cyc_addr = addr_ff;
    unique case (st_ff)
      S_PWRUP: if (tmr_ff == '0) nxt_st = S_RECOVER;
      S_RECOVER: if (tmr_ff == '0) nxt_st = S_IDLE;
      S_IDLE: begin
        if (wr_ctrl && op_legal) begin
          unique case (op)
            OP_ERASE: nxt_st = S_SETUP_WR;
            OP_SUSPEND: nxt_st = S_SUSP_WR;
            OP_RESUME: nxt_st = S_RESUME_WR;
            OP_READ: nxt_st = (suspended_ff && same_blk) ? S_IDLE : S_READ;
            default: nxt_st = S_CMD_WR;
          endcase
        end
      end
      S_SETUP_WR: begin
        cyc_go = 1'b1;
        cyc_wdata = CMD_ERASE_SETUP; // [RULE2]
        if (cyc_done) nxt_st = S_CONFIRM_WR;
      end
      S_CONFIRM_WR: begin
        cyc_go = 1'b1;
        cyc_wdata = CMD_CONFIRM; // [RULE2] [RULE3] [RULE24]
        if (cyc_done) nxt_st = S_POLL;
      end
      S_SUSP_WR, S_RESUME_WR: begin
        cyc_go = 1'b1;
        cyc_wdata = (st_ff == S_SUSP_WR) ? CMD_SUSPEND : CMD_CONFIRM; // [RULE25]
        if (cyc_done) nxt_st = S_POLL;
      end
      S_POLL: begin
        // Any read while erasing gives status [RULE5]
        cyc_go = 1'b1;
        cyc_read = 1'b1;
        if (cyc_done && cyc_rdata[SR_READY]) nxt_st = S_IDLE; // [RULE6]
        else if (cyc_done && susp_req_ff) nxt_st = S_SUSP_WR; // [RULE8]
      end
      S_CMD_WR: begin
        cyc_go = 1'b1;
        cyc_wdata = (pend_ff == OP_CLEAR) ? CMD_CLEAR_STATUS : // [RULE14]
                    (pend_ff == OP_READ_STATUS) ? CMD_READ_STATUS : CMD_READ_ARRAY; // [RULE21]
        if (cyc_done) nxt_st = S_IDLE;
      end
      S_READ: begin
        cyc_go = 1'b1;
        cyc_read = 1'b1;
        if (cyc_done) nxt_st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= S_PWRUP;
      tmr_ff <= (CNT_W+3)'(RESET_LOW_CYC);
      addr_ff <= '0;
      status_ff <= '0;
      data_ff <= '0;
      pend_ff <= '0;
      busy_ff <= 1'b1;
      erasing_ff <= 1'b0;
      suspended_ff <= 1'b0;
      boot_ff <= 1'b0;
      pwrdn_ff <= 1'b0;
      susp_req_ff <= 1'b0;
      blk_ff <= '0;
      reset_powerdown_n <= 1'b0; // Held low through ramp [RULE20]
      boot_unlock_voltage <= 1'b0;
      write_protect_n <= 1'b1;
      program_supply_high <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      busy_ff <= (nxt_st != S_IDLE);
      if (susp_take) susp_req_ff <= 1'b1;
      if (nxt_st != S_POLL) susp_req_ff <= 1'b0;
      if (tmr_ff != '0) tmr_ff <= tmr_ff - 1'b1;
      if (st_ff == S_PWRUP && tmr_ff == '0) begin
        reset_powerdown_n <= 1'b1;
        tmr_ff <= (CNT_W+3)'(RESET_REC_CYC);
        status_ff <= '0; // Device starts cleared in array read [RULE19]
      end
      if (reg_wr && reg_addr == REG_PIN) begin
        pwrdn_ff <= reg_wdata[0];
        reset_powerdown_n <= !reg_wdata[0]; // [RULE17]
        boot_ff <= reg_wdata[1];
        if (reg_wdata[0]) begin
          // Deep power-down resets the device status and aborts its erase [RULE19]
          status_ff <= '0;
          erasing_ff <= 1'b0;
          suspended_ff <= 1'b0;
        end
      end
      if (st_ff == S_IDLE && wr_ctrl && op_legal) begin
        pend_ff <= op;
        if (op == OP_ERASE) blk_ff <= reg_wdata[BLK_HI+8:BLK_LO+8]; // [RULE24]
        if (op == OP_ERASE || (op == OP_READ && !(suspended_ff && same_blk))) begin
          addr_ff <= reg_wdata[ADDR_W+7:8];
        end
      end
      if (nxt_st == S_SETUP_WR || nxt_st == S_RESUME_WR) begin
        program_supply_high <= 1'b1;
        boot_unlock_voltage <= boot_ff; // [RULE7]
        write_protect_n <= !boot_ff;
      end
      if (st_ff == S_CONFIRM_WR && cyc_done) erasing_ff <= 1'b1;
      if (st_ff == S_RESUME_WR && cyc_done) suspended_ff <= 1'b0; // [RULE12] [RULE22]
      if (st_ff == S_POLL && cyc_done) begin
        status_ff <= cyc_rdata;
        if (cyc_rdata[SR_READY]) begin
          program_supply_high <= 1'b0;
          boot_unlock_voltage <= 1'b0;
          write_protect_n <= 1'b1;
          if (cyc_rdata[SR_SUSPENDED]) begin
            suspended_ff <= 1'b1; // [RULE9]
          end else begin
            // Done; an erase error means retries ran out [RULE23] [RULE1]
            erasing_ff <= 1'b0;
            suspended_ff <= 1'b0;
          end
          // Wrong confirm leaves both error bits [RULE4]
        end
      end
      if (st_ff == S_CMD_WR && cyc_done && pend_ff == OP_CLEAR) begin
        status_ff[SR_ERASE_ERR:SR_SUPPLY] <= '0;
      end
      if (st_ff == S_READ && cyc_done) data_ff <= cyc_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Bus cycle engine
  // ----------------------------------------------------------------
  flash_bus_cycle #(.STROBE_CYC(STROBE_CYC)) u_cycle (
    .clk(clk),
    .rst_n(rst_n),
    .go(cyc_go && !cyc_done),
    .is_read(cyc_read),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .data_in(flash_din),
    .ctl(flash_ctl),
    .dout(flash_dout),
    .rdata(cyc_rdata),
    .done(cyc_done)
  );

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  wire [31:0] rd_mux =
    (reg_addr == REG_CTRL) ? {27'h0, pwrdn_ff, suspended_ff, erasing_ff, 1'b0, busy_ff} :
    (reg_addr == REG_ADDR) ? {12'h0, addr_ff} :
    (reg_addr == REG_STATUS) ? {24'h0, status_ff} :
    (reg_addr == REG_DATA) ? {24'h0, data_ff} :
    (reg_addr == REG_ERR) ? {29'h0, err_now} :
    (reg_addr == REG_PIN) ? {30'h0, boot_ff, pwrdn_ff} : 32'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end
endmodule
`default_nettype wire

//--- testbench/flash_erase_monitor.sv
// Checker of the flash-side and register-side ports of the erase host
`timescale 1ns/1ps
`default_nettype none
module flash_erase_monitor #(
  parameter int STROBE_CYC = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire flash_ctl_pkg::flash_ctl_s flash_ctl,
  input wire flash_ctl_pkg::flash_dout_s flash_dout,
  input wire logic reset_powerdown_n,
  input wire logic boot_unlock_voltage,
  input wire logic write_protect_n,
  input wire logic program_supply_high
);
  import flash_ctl_pkg::*;
  logic [7:0] low_ff;
  logic [7:0] nxt_low;
  // Counts cycles of the current write strobe
  assign nxt_low = flash_ctl.wr_n ? 8'h00 : low_ff + 8'h01;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) low_ff <= 8'h00;
    else low_ff <= nxt_low;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_WR_SELECT: assert property (!flash_ctl.wr_n |-> !flash_ctl.chip_sel_n)
    else $error("write strobe without chip select");
  AST_STROBE_EXCL: assert property (!(flash_ctl.wr_n == 1'b0 && flash_ctl.rd_n == 1'b0))
    else $error("read and write strobes low together");
  AST_WR_DRIVE: assert property (!flash_ctl.wr_n |-> flash_dout.wdata_oe)
    else $error("write strobe without data drive");
  AST_WR_HOLD: assert property (!flash_ctl.wr_n && $past(!flash_ctl.wr_n)
    |-> $stable(flash_ctl.addr) && $stable(flash_dout.wdata))
    else $error("address or data moved under write strobe");
  AST_RD_HOLD: assert property (!flash_ctl.rd_n && $past(!flash_ctl.rd_n)
    |-> $stable(flash_ctl.addr))
    else $error("address moved under read strobe");
  AST_WR_LEN: assert property ($rose(flash_ctl.wr_n) |-> low_ff == STROBE_CYC)
    else $error("write strobe length wrong");
  AST_CONFIRM_SUPPLY: assert property (!flash_ctl.wr_n && flash_dout.wdata == CMD_CONFIRM
    |-> program_supply_high)
    else $error("confirm written without program supply");
  AST_PWRDN_IDLE: assert property (!reset_powerdown_n |-> flash_ctl.chip_sel_n && flash_ctl.wr_n)
    else $error("bus access while in power-down");
  AST_BOOT_PIN: assert property (boot_unlock_voltage |-> !write_protect_n)
    else $error("boot unlock without protect pin");
  AST_RDATA_ONE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  cover property ($rose(flash_ctl.wr_n) && flash_dout.wdata == CMD_CONFIRM);
  cover property (!reset_powerdown_n ##1 reset_powerdown_n);
  cover property ($fell(flash_ctl.rd_n));
endmodule
bind flash_erase_host flash_erase_monitor #(.STROBE_CYC(STROBE_CYC)) u_mon (
  .clk(clk), .arst_n(arst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .flash_ctl(flash_ctl), .flash_dout(flash_dout), .reset_powerdown_n(reset_powerdown_n),
  .boot_unlock_voltage(boot_unlock_voltage), .write_protect_n(write_protect_n),
  .program_supply_high(program_supply_high));
`default_nettype wire

//--- testbench/flash_dev_model.sv
// Behavioural flash device: command decoder, erase engine and status register
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter int ERASE_POLLS = 3
) (
  input wire flash_ctl_pkg::flash_ctl_s ctl,
  input wire flash_ctl_pkg::flash_dout_s dout,
  input wire logic rp_n,
  input wire logic supply,
  input wire logic fail_erase,
  output logic [7:0] din
);
  import flash_ctl_pkg::*;
  logic [7:0] sr = 8'h80, last = 8'h00, cmd, blk = 8'h00;
  logic [255:0] erased = '0;
  logic smode = 0, setup = 0, erasing = 0, susp = 0;
  int polls = 0;
  always @(negedge rp_n) begin
    sr = 8'h80; smode = 0; setup = 0; erasing = 0; susp = 0;
  end
  always @(posedge ctl.wr_n) if (rp_n) begin
    cmd = dout.wdata;
    if (erasing && !sr[6]) begin
      if (cmd == CMD_SUSPEND) susp = 1;
      else if (cmd == CMD_CONFIRM) susp = 0;
    end else if (sr[6]) begin
      if (cmd == CMD_READ_ARRAY) smode = 0;
      if (cmd == CMD_READ_STATUS) smode = 1;
      if (cmd == CMD_CONFIRM) begin sr[7:6] = 2'b00; susp = 0; smode = 1; end
    end else if (setup) begin
      setup = 0; smode = 1;
      if (cmd != CMD_CONFIRM) sr[5:4] = 2'b11;
      else if (!supply) sr[5] = 1;
      else if (!sr[3]) begin
        blk = ctl.addr[BLK_HI:BLK_LO]; erasing = 1; polls = 0; sr[7] = 0;
      end
      if (cmd == CMD_CONFIRM && !supply) sr[3] = 1;
    end else begin
      if (cmd == CMD_READ_ARRAY) smode = 0;
      if (cmd == CMD_READ_STATUS) smode = 1;
      if (cmd == CMD_CLEAR_STATUS) sr[5:3] = 3'b000;
      if (cmd == CMD_ERASE_SETUP) setup = 1;
    end
  end
  always @(negedge ctl.rd_n) if (rp_n) begin
    if (erasing && !sr[6]) begin
      polls++;
      if (susp) sr[7:6] = 2'b11;
      else if (polls >= ERASE_POLLS) begin
        erasing = 0; sr[7] = 1;
        if (fail_erase) sr[5] = 1;
        else erased[blk] = 1;
      end
    end
    if (smode) last = sr;
    else if (erased[ctl.addr[BLK_HI:BLK_LO]]) last = 8'hff;
    else last = ctl.addr[7:0] ^ 8'h5a;
  end
  // Released data lines show the inverse of the last value
  assign din = ctl.rd_n ? ~last : last;
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the flash erase host
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import flash_ctl_pkg::*;
  logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, fail_erase = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
  flash_ctl_s fctl;
  flash_dout_s fdout;
  logic [7:0] fdin;
  logic rp_n, unlock, wp_n, vpp;
  int mismatches = 0, tests_run = 0, cyc = 0;
  initial forever #2.5 clk = ~clk;
  flash_erase_host #(.STROBE_CYC(2), .RESET_LOW_CYC(2), .RESET_REC_CYC(4)) u_dut (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_ctl(fctl),
    .flash_dout(fdout), .flash_din(fdin), .reset_powerdown_n(rp_n),
    .boot_unlock_voltage(unlock), .write_protect_n(wp_n), .program_supply_high(vpp));
  flash_dev_model u_flash (.ctl(fctl), .dout(fdout), .rp_n(rp_n), .supply(vpp),
    .fail_erase(fail_erase), .din(fdin));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task automatic rd(logic [3:0] a);
    reg_addr <= a; reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    @(posedge clk);
    rv = reg_rdata;
  endtask
  task automatic wait_idle();
    rv = 32'h1;
    for (int i = 0; i < 300 && rv[0] !== 1'b0; i++) rd(REG_CTRL);
    check("busy", rv[0], 0);
  endtask
  task automatic op(logic [2:0] o, logic [19:0] a);
    wr(REG_CTRL, {4'h0, a, 5'h00, o});
    wait_idle();
  endtask
  task automatic pins(logic [31:0] v);
    wr(REG_PIN, v);
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1;
    repeat (3) @(posedge clk);
    wait_idle();
    check("pins", {rp_n, unlock, wp_n}, 3'b101);
    $display("test reset finished");
    op(OP_ERASE, 20'h03456);
    rd(REG_STATUS); check("status", rv, 32'h80);
    rd(REG_ERR); check("err", rv, 32'h0);
    rd(REG_ADDR); check("addr", rv, 32'h03456);
    op(OP_READ_ARRAY, 20'h00000);
    op(OP_READ, 20'h03abc);
    rd(REG_DATA); check("erased", rv, 32'hff);
    op(OP_READ, 20'h04abc);
    rd(REG_DATA); check("other", rv, 32'he6);
    $display("test erase finished");
    fail_erase <= 1;
    op(OP_ERASE, 20'h05010);
    rd(REG_STATUS); check("status", rv, 32'ha0);
    rd(REG_ERR); check("err", rv, 32'h4);
    $display("test erase error finished");
    fail_erase <= 0;
    pins(32'h1);
    check("pwrdn", rp_n, 0);
    pins(32'h0);
    wait_idle();
    check("pwrup", rp_n, 1);
    op(OP_READ_STATUS, 20'h00000);
    rd(REG_STATUS); check("status", rv, 32'h0);
    $display("test power-down finished");
    fail_erase <= 1;
    op(OP_ERASE, 20'h06000);
    op(OP_CLEAR, 20'h00000);
    op(OP_READ_STATUS, 20'h00000);
    rd(REG_STATUS); check("cleared", rv, 32'h80);
    rd(REG_ERR); check("err", rv, 32'h0);
    op(OP_READ_ARRAY, 20'h00000);
    op(OP_READ, 20'h06010);
    rd(REG_DATA); check("failed", rv, 32'h4a);
    $display("test clear finished");
    fail_erase <= 0;
    pins(32'h2);
    wr(REG_CTRL, {4'h0, 20'h07000, 5'h00, OP_ERASE});
    repeat (3) @(posedge clk);
    check("boot", {unlock, wp_n, vpp}, 3'b101);
    repeat (11) @(posedge clk);
    op(OP_SUSPEND, 20'h00000);
    rd(REG_STATUS); check("suspend", rv, 32'hc0);
    rd(REG_CTRL); check("state", rv, 32'hc);
    check("released", {unlock, wp_n, vpp}, 3'b010);
    op(OP_READ_ARRAY, 20'h00000);
    op(OP_READ, 20'h08123);
    rd(REG_DATA); check("outside", rv, 32'h79);
    op(OP_READ, 20'h07abc);
    rd(REG_DATA); check("inside", rv, 32'h79);
    op(OP_RESUME, 20'h00000);
    rd(REG_STATUS); check("resumed", rv, 32'h80);
    rd(REG_CTRL); check("state", rv, 32'h0);
    op(OP_READ_ARRAY, 20'h00000);
    op(OP_READ, 20'h07abc);
    rd(REG_DATA); check("erased", rv, 32'hff);
    pins(32'h0);
    $display("test boot suspend finished");
    stop_test();
  end
endmodule
`default_nettype wire
